// >>> burst_pkg.sv
// Shared constants and types for the burst flash read path
package burst_pkg;

  // ==========================================================================
  // Widths
  localparam int WORD_W = 16;
  localparam int CNT_W = 6;
  localparam int WAIT_W = 4;
  localparam int CMD_W = 8;
  localparam int FIFO_W = WORD_W + 1;
  localparam int FIFO_BOUNDARY_BIT = WORD_W;

  // ==========================================================================
  // Command codes, taken from the low address byte of a write cycle
  localparam logic [CMD_W-1:0] CMD_CFG_WRITE_LOW = 8'hC0;
  localparam logic [CMD_W-1:0] CMD_CFG_WRITE_HIGH = 8'hC1;
  localparam logic [CMD_W-1:0] CMD_CFG_READ = 8'hC6;
  // Address bit that picks the high configuration word on a config read
  localparam int CFG_SELECT_BIT = 0;

  // ==========================================================================
  // Configuration fields
  localparam int READ_MODE_SELECT_BIT = 15;
  localparam int RESERVED_BIT_FOURTEEN = 14;
  localparam int WAIT_LOW_HI = 13;
  localparam int WAIT_LOW_LO = 11;
  localparam int WAIT_COUNT_MSB = 0;
  localparam int LEN_HI = 1;
  localparam int LEN_LO = 0;
  localparam logic READ_MODE_SYNC = 1'b0;

  localparam logic [1:0] LEN_CODE_16 = 2'h1;
  localparam logic [1:0] LEN_CODE_32 = 2'h2;
  localparam logic [CNT_W-1:0] BURST_WORDS_8 = 6'h08;
  localparam logic [CNT_W-1:0] BURST_WORDS_16 = 6'h10;
  localparam logic [CNT_W-1:0] BURST_WORDS_32 = 6'h20;
  localparam logic [CNT_W-1:0] SINGLE_WORD = 6'h01;

  // 128-word line: low address bits that are zero at a line start
  localparam int LINE_BITS = 7;

  // Reset values: asynchronous read mode, reserved bit 14 set, wait code 0101
  localparam logic [WORD_W-1:0] BURST_CONFIG_LOW_RESET = 16'hE800;
  localparam logic [WORD_W-1:0] BURST_CONFIG_HIGH_RESET = 16'h0000;

  // ==========================================================================
  // Link sequencer states, Gray coded along idle, wait, data, boundary gap
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DATA = 2'b11,
    ST_GAP = 2'b10
  } link_state_t;

endpackage

// >>> burst_fifo.sv
// Small synchronous word FIFO with flush, valid and ready on both sides
module burst_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  // DEPTH must be a power of two so that the pointers wrap by themselves
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slots;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [CW-1:0] count;
  } fifo_regs_t;

  fifo_regs_t q;
  fifo_regs_t next_q;
  logic push;
  logic pop;
  logic [PW-1:0] wr_at;

  // ==========================================================================
  // Flush empties the queue but still accepts the word offered in that cycle
  assign in_ready = flush || (q.count != CW'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data = q.slots[q.rd];

  always_comb begin
    next_q = q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready && !flush;
    wr_at = flush ? '0 : q.wr;
    if (flush) begin
      next_q.rd = '0;
      next_q.count = '0;
    end else if (pop) begin
      next_q.rd = q.rd + PW'(1);
    end
    next_q.wr = wr_at;
    if (push) begin
      next_q.slots[wr_at] = in_data;
      next_q.wr = wr_at + PW'(1);
    end
    next_q.count = (flush ? CW'(0) : q.count) + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

// >>> burst_flash.sv
// Burst read sequencer and configuration registers of the burst flash device
// ============================================================================
// Notes on behaviour
// - Without wrap a burst of 8, 16 or 32 words reads ascending addresses from the start and then stops.
// - Each 128-word line crossing inside a burst inserts one extra wait state into the data stream.
// - Two 16-bit configuration registers hold the read mode and burst settings.
// - Reset returns the device to asynchronous read mode with every configuration field at default.
// - The configuration-read command returns the current configuration contents.
// - Read mode bit 15 of the low register at 0 enables synchronous burst reading.
// - Wait code 0000 presents the first word at the second rising edge after the address latch.
// - Wait code 0001 presents the first word at the third rising edge after the address latch.
module burst_flash #(
  parameter int ADDR_W = 10,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load_valid,
  output logic load_ready,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [burst_pkg::WORD_W-1:0] load_data,
  output logic sync_mode,
  output logic burst_busy,
  input wire logic burst_clk,
  input wire logic chip_select_n,
  input wire logic address_valid_strobe_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [burst_pkg::WORD_W-1:0] data_in,
  output logic [burst_pkg::WORD_W-1:0] data_out,
  output logic data_oe,
  output logic word_valid
);

  // ==========================================================================
  // Types
  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    logic busy_s1;
    logic busy_s2;
  } core_regs_t;

  typedef struct packed {
    burst_pkg::link_state_t state;
    logic [burst_pkg::WORD_W-1:0] cfg_low;
    logic [burst_pkg::WORD_W-1:0] cfg_high;
    logic cfg_read;
    logic [ADDR_W-1:0] fptr;
    logic [burst_pkg::CNT_W-1:0] fetch_left;
    logic [burst_pkg::CNT_W-1:0] pop_left;
    logic [burst_pkg::WAIT_W-1:0] wait_cnt;
    logic [burst_pkg::WORD_W-1:0] dout;
    logic oe;
    logic wvalid;
    logic busy;
  } link_regs_t;

  localparam link_regs_t LINK_RESET = '{
    state: burst_pkg::ST_IDLE,
    cfg_low: burst_pkg::BURST_CONFIG_LOW_RESET,
    cfg_high: burst_pkg::BURST_CONFIG_HIGH_RESET,
    default: '0
  };

  // ==========================================================================
  // Array contents, loaded from the core side
  // Written on mclk and read on burst_clk; a word must not be reloaded while
  // a burst is reading it, which is the price of a plain dual-clock array.
  logic [burst_pkg::WORD_W-1:0] mem [2**ADDR_W];

  assign load_ready = !rst;

  always_ff @(posedge mclk) begin
    if (load_valid && load_ready) begin
      mem[load_addr] <= load_data;
    end
  end

  // ==========================================================================
  // Reset into the link domain
  // The burst clock must run for a few edges while rst is high.
  logic lrst_s1;
  logic lrst_s2;

  always_ff @(posedge burst_clk) begin
    lrst_s1 <= rst;
    lrst_s2 <= lrst_s1;
  end

  // ==========================================================================
  // Link sequencer
  link_regs_t l;
  link_regs_t next_l;
  logic latch;
  logic [burst_pkg::WAIT_W-1:0] wait_code;
  logic [burst_pkg::CNT_W-1:0] burst_len;
  logic [burst_pkg::CNT_W-1:0] start_len;
  logic [burst_pkg::WAIT_W-1:0] start_wait;
  logic [burst_pkg::WORD_W-1:0] first_word;
  logic drain;
  logic fifo_flush;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [burst_pkg::FIFO_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [burst_pkg::FIFO_W-1:0] fifo_out_data;

  // Wait code spans the msb in the high register and three bits of the low
  assign wait_code = {l.cfg_high[burst_pkg::WAIT_COUNT_MSB],
                      l.cfg_low[burst_pkg::WAIT_LOW_HI:burst_pkg::WAIT_LOW_LO]};

  always_comb begin
    case (l.cfg_low[burst_pkg::LEN_HI:burst_pkg::LEN_LO])
      burst_pkg::LEN_CODE_16: burst_len = burst_pkg::BURST_WORDS_16;
      burst_pkg::LEN_CODE_32: burst_len = burst_pkg::BURST_WORDS_32;
      default: burst_len = burst_pkg::BURST_WORDS_8;
    endcase
  end

  always_comb begin
    next_l = l;
    latch = !chip_select_n && !address_valid_strobe_n;
    fifo_flush = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_data = {1'b0, mem[l.fptr]};
    fifo_out_ready = 1'b0;
    drain = 1'b0;
    start_len = burst_pkg::SINGLE_WORD;
    start_wait = '0;
    first_word = mem[addr];
    next_l.wvalid = 1'b0;

    if (chip_select_n) begin
      // Deselect ends any burst at once and discards prefetched words
      fifo_flush = 1'b1;
      next_l.state = burst_pkg::ST_IDLE;
      next_l.fetch_left = '0;
      next_l.pop_left = '0;
    end else if (latch && !write_enable_n) begin
      // Command cycle: address low byte is the command, data bus the value
      fifo_flush = 1'b1;
      next_l.state = burst_pkg::ST_IDLE;
      next_l.fetch_left = '0;
      next_l.pop_left = '0;
      case (addr[burst_pkg::CMD_W-1:0])
        burst_pkg::CMD_CFG_WRITE_LOW: next_l.cfg_low = data_in;
        burst_pkg::CMD_CFG_WRITE_HIGH: next_l.cfg_high = data_in;
        burst_pkg::CMD_CFG_READ: next_l.cfg_read = 1'b1;
        default: next_l.cfg_read = l.cfg_read;
      endcase
    end else if (latch) begin
      // A new address and strobe restart the sequencer from any state
      fifo_flush = 1'b1;
      if (l.cfg_read) begin
        first_word = addr[burst_pkg::CFG_SELECT_BIT] ? l.cfg_high : l.cfg_low;
        next_l.cfg_read = 1'b0;
      end else if (l.cfg_low[burst_pkg::READ_MODE_SELECT_BIT] == burst_pkg::READ_MODE_SYNC) begin
        start_len = burst_len;
        start_wait = wait_code;
      end
      // First word goes in on the latch edge so code 0000 can meet its edge
      fifo_in_valid = 1'b1;
      fifo_in_data = {1'b0, first_word};
      next_l.fptr = addr + ADDR_W'(1);
      next_l.fetch_left = start_len - burst_pkg::SINGLE_WORD;
      next_l.pop_left = start_len;
      next_l.wait_cnt = start_wait;
      next_l.state = burst_pkg::ST_WAIT;
    end else begin
      // Prefetch ascending words; a full queue stalls the fetch pointer
      if (l.state != burst_pkg::ST_IDLE && l.fetch_left != '0) begin
        fifo_in_valid = 1'b1;
        fifo_in_data = {(l.fptr[burst_pkg::LINE_BITS-1:0] == '0), mem[l.fptr]};
        if (fifo_in_ready) begin
          next_l.fptr = l.fptr + ADDR_W'(1);
          next_l.fetch_left = l.fetch_left - burst_pkg::SINGLE_WORD;
        end
      end

      case (l.state)
        burst_pkg::ST_WAIT: begin
          // One edge per code step before the first word leaves
          if (l.wait_cnt != '0) begin
            next_l.wait_cnt = l.wait_cnt - burst_pkg::WAIT_W'(1);
          end else begin
            drain = 1'b1;
          end
        end
        burst_pkg::ST_DATA: drain = 1'b1;
        burst_pkg::ST_GAP: drain = 1'b1;
        default: drain = 1'b0;
      endcase

      if (drain && fifo_out_valid) begin
        if (fifo_out_data[burst_pkg::FIFO_BOUNDARY_BIT] && l.state != burst_pkg::ST_GAP) begin
          // Hold the line-start word back one edge
          next_l.state = burst_pkg::ST_GAP;
        end else begin
          fifo_out_ready = 1'b1;
          next_l.dout = fifo_out_data[burst_pkg::WORD_W-1:0];
          next_l.wvalid = 1'b1;
          next_l.pop_left = l.pop_left - burst_pkg::SINGLE_WORD;
          // Stop after the last word; no wrap back to the group start
          if (l.pop_left == burst_pkg::SINGLE_WORD) begin
            next_l.state = burst_pkg::ST_IDLE;
          end else begin
            next_l.state = burst_pkg::ST_DATA;
          end
        end
      end
    end

    // Keep driving until the host has sampled the last word
    next_l.oe = (next_l.state != burst_pkg::ST_IDLE) || next_l.wvalid;
    next_l.busy = (next_l.state != burst_pkg::ST_IDLE);
  end

  always_ff @(posedge burst_clk) begin
    if (lrst_s2) begin
      l <= LINK_RESET;
    end else begin
      l <= next_l;
    end
  end

  burst_fifo #(
    .W(burst_pkg::FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) prefetch (
    .clk(burst_clk),
    .rst(lrst_s2),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign data_out = l.dout;
  assign word_valid = l.wvalid;
  // Registered drive window, gated by the output enable pin as on the bus
  assign data_oe = l.oe && !output_enable_n;

  // ==========================================================================
  // Status toward the core clock, each a level through two flip-flops
  core_regs_t c;
  core_regs_t next_c;

  always_comb begin
    next_c = c;
    next_c.mode_s1 = l.cfg_low[burst_pkg::READ_MODE_SELECT_BIT];
    next_c.mode_s2 = c.mode_s1;
    next_c.busy_s1 = l.busy;
    next_c.busy_s2 = c.busy_s1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      c <= '0;
      c.mode_s1 <= !burst_pkg::READ_MODE_SYNC;
      c.mode_s2 <= !burst_pkg::READ_MODE_SYNC;
    end else begin
      c <= next_c;
    end
  end

  assign sync_mode = (c.mode_s2 == burst_pkg::READ_MODE_SYNC);
  assign burst_busy = c.busy_s2;

endmodule

// >>> burst_flash_sva.sv
// Assertion checker for the burst flash link and status outputs
module burst_flash_sva #(
  parameter int ADDR_W = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load_valid,
  input wire logic load_ready,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [burst_pkg::WORD_W-1:0] load_data,
  input wire logic sync_mode,
  input wire logic burst_busy,
  input wire logic burst_clk,
  input wire logic chip_select_n,
  input wire logic address_valid_strobe_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [burst_pkg::WORD_W-1:0] data_in,
  input wire logic [burst_pkg::WORD_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic word_valid
);
  // ========
  // Shadow of the configuration and of the running burst
  logic [15:0] lo, hi;
  logic arm;
  logic [5:0] cnt, lim;
  logic [ADDR_W-1:0] ptr;
  wire lat = !chip_select_n && !address_valid_strobe_n;
  wire rd = lat && write_enable_n;
  wire cmd = lat && !write_enable_n;
  wire [7:0] op = addr[7:0];
  wire burst = !lo[15] && !arm;
  wire [3:0] code = burst ? {hi[0], lo[13:11]} : 4'h0;
  wire [5:0] len = lo[1:0] == burst_pkg::LEN_CODE_16 ? burst_pkg::BURST_WORDS_16 :
    lo[1:0] == burst_pkg::LEN_CODE_32 ? burst_pkg::BURST_WORDS_32 : burst_pkg::BURST_WORDS_8;
  always_ff @(posedge burst_clk) begin
    if (rst) begin
      lo <= burst_pkg::BURST_CONFIG_LOW_RESET;
      hi <= burst_pkg::BURST_CONFIG_HIGH_RESET;
      arm <= 1'b0;
      cnt <= 6'h00;
      lim <= 6'h00;
    end else begin
      if (cmd && op == burst_pkg::CMD_CFG_WRITE_LOW) lo <= data_in;
      if (cmd && op == burst_pkg::CMD_CFG_WRITE_HIGH) hi <= data_in;
      if (cmd && op == burst_pkg::CMD_CFG_READ) arm <= 1'b1;
      else if (rd) arm <= 1'b0;
      // A command aborts the burst, so no word may follow it
      if (cmd) lim <= 6'h00;
      if (rd) begin
        cnt <= 6'h00;
        ptr <= addr;
        lim <= burst ? len : burst_pkg::SINGLE_WORD;
      end else if (word_valid) begin
        cnt <= cnt + 6'h01;
        ptr <= ptr + ADDR_W'(1);
      end
    end
  end
  // ========
  // Properties
  property p_rst;
    @(posedge mclk) $fell(rst) |-> !sync_mode && !burst_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("status not cleared by reset");
  property p_wait0;
    @(posedge burst_clk) disable iff (rst) rd && code == 4'h0 |-> ##1 !word_valid ##1 word_valid;
  endproperty
  a_wait0: assert property (p_wait0) else $error("first word late for code 0");
  property p_wait1;
    @(posedge burst_clk) disable iff (rst) rd && code == 4'h1 |-> ##1 !word_valid [*2] ##1 word_valid;
  endproperty
  a_wait1: assert property (p_wait1) else $error("first word late for code 1");
  property p_len;
    @(posedge burst_clk) disable iff (rst) word_valid |-> cnt < lim;
  endproperty
  a_len: assert property (p_len) else $error("burst longer than set");
  property p_cont;
    @(posedge burst_clk) disable iff (rst) word_valid && cnt != 6'h00 && ptr[6:0] != 7'h00 |-> $past(word_valid);
  endproperty
  a_cont: assert property (p_cont) else $error("hole inside a line");
  property p_gap;
    @(posedge burst_clk) disable iff (rst) word_valid && cnt != 6'h00 && ptr[6:0] == 7'h00 |-> !$past(word_valid);
  endproperty
  a_gap: assert property (p_gap) else $error("no wait at line crossing");
  property p_cfgrd;
    @(posedge burst_clk) disable iff (rst) rd && arm |-> ##1 !word_valid ##1 word_valid ##1 !word_valid;
  endproperty
  a_cfgrd: assert property (p_cfgrd) else $error("config read not one word");
  property p_sync;
    @(posedge burst_clk) disable iff (rst) cmd && op == burst_pkg::CMD_CFG_WRITE_LOW |=> sync_mode == !lo[15];
  endproperty
  a_sync: assert property (p_sync) else $error("sync flag wrong");
  property p_desel;
    @(posedge burst_clk) disable iff (rst) chip_select_n |=> !word_valid && !data_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("output after deselect");
  property p_oe;
    @(posedge burst_clk) disable iff (rst) rd |=> data_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("bus not driven after read latch");
  c_gap: cover property (@(posedge burst_clk) word_valid && cnt != 6'h00 && ptr[6:0] == 7'h00);
  c_cfg: cover property (@(posedge burst_clk) rd && arm);
  c_long: cover property (@(posedge burst_clk) word_valid && cnt == 6'h1F);
endmodule

bind burst_flash burst_flash_sva #(.ADDR_W(ADDR_W)) u_sva (.mclk(mclk), .rst(rst), .load_valid(load_valid),
  .load_ready(load_ready), .load_addr(load_addr), .load_data(load_data), .sync_mode(sync_mode),
  .burst_busy(burst_busy), .burst_clk(burst_clk), .chip_select_n(chip_select_n),
  .address_valid_strobe_n(address_valid_strobe_n), .write_enable_n(write_enable_n),
  .output_enable_n(output_enable_n), .addr(addr), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .word_valid(word_valid));

// >>> host_model.sv
// Host controller model that clocks and addresses the burst link
module host_model #(
  parameter int ADDR_W = 10
) (
  output logic burst_clk,
  output logic chip_select_n,
  output logic address_valid_strobe_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic [ADDR_W-1:0] addr,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic word_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] got [$];
  int at [$];
  int edge_n;
  initial begin
    burst_clk = 1'b0;
    chip_select_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    write_enable_n = 1'b1;
    output_enable_n = 1'b1;
    addr = '0;
    data_in = '0;
    edge_n = 0;
  end
  // ========
  // One link cycle; the clock stands still unless a task runs it
  task automatic tick();
    #32;
    if (word_valid === 1'b1) begin
      got.push_back(data_out);
      at.push_back(edge_n);
    end
    burst_clk = 1'b1;
    edge_n++;
    #32;
    burst_clk = 1'b0;
  endtask
  // Latch an address or command, then clock n more cycles
  task automatic frame(input logic [ADDR_W-1:0] a, input logic wr, input logic [15:0] d, input int n);
    if (wr && a[7:0] == burst_pkg::CMD_CFG_WRITE_LOW) d[14] = 1'b1;
    #1.3;
    addr = a;
    data_in = d;
    chip_select_n = 1'b0;
    address_valid_strobe_n = 1'b0;
    write_enable_n = !wr;
    output_enable_n = wr;
    edge_n = 0;
    tick();
    got.delete();
    at.delete();
    // Released lines show the inverse so stale values cannot pass
    address_valid_strobe_n = 1'b1;
    write_enable_n = 1'b1;
    addr = ~addr;
    data_in = ~data_in;
    repeat (n) tick();
    // One deselect edge closes every frame, so an abort is seen on the pins
    chip_select_n = 1'b1;
    tick();
    output_enable_n = 1'b1;
  endtask
endmodule

// >>> tb_burst_flash.sv
// Self-checking bench for the burst flash read path
module tb_burst_flash;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 10;
  logic mclk, rst, load_valid, load_ready, sync_mode, burst_busy, data_oe, word_valid;
  logic burst_clk, chip_select_n, address_valid_strobe_n, write_enable_n, output_enable_n;
  logic [AW-1:0] load_addr, addr;
  logic [15:0] load_data, data_in, data_out;
  logic [15:0] mem [1024];
  int corner [4] = '{60, 126, 1022, 127};
  int errors, n_compared;
  int seed = 32'hD643;
  burst_flash #(.ADDR_W(AW), .FIFO_DEPTH(4)) u_dut (.mclk(mclk), .rst(rst), .load_valid(load_valid),
    .load_ready(load_ready), .load_addr(load_addr), .load_data(load_data), .sync_mode(sync_mode),
    .burst_busy(burst_busy), .burst_clk(burst_clk), .chip_select_n(chip_select_n),
    .address_valid_strobe_n(address_valid_strobe_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .word_valid(word_valid));
  host_model #(.ADDR_W(AW)) u_host (.burst_clk(burst_clk), .chip_select_n(chip_select_n),
    .address_valid_strobe_n(address_valid_strobe_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .word_valid(word_valid));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ========
  // Compare and expectation helpers
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_num(input int got, input int exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic int exp_edge(input int a, input int i, input int code);
    int e = 2 + code + i;
    for (int j = 1; j <= i; j++) if ((a + j) % 128 == 0) e++;
    return e;
  endfunction
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ========
  // Link sequences
  task automatic cfg_word(input int sel, input logic [15:0] exp);
    u_host.frame(AW'(burst_pkg::CMD_CFG_READ), 1'b1, 16'h0000, 1);
    u_host.frame(AW'(sel), 1'b0, 16'h0000, 5);
    check_num(u_host.got.size(), 1);
    check_word(u_host.got[0], exp);
  endtask
  task automatic burst(input int a, input int code, input int n);
    fork
      u_host.frame(AW'(a), 1'b0, 16'h0000, n + code + 8);
      begin
        // Past the initial wait a long burst must still show busy, a single read not
        #(64 * (code + 3));
        check_word({15'h0000, burst_busy}, {15'h0000, n > 1});
      end
    join
    check_num(u_host.got.size(), n);
    for (int i = 0; i < n; i++) begin
      check_word(u_host.got[i], mem[(a + i) % 1024]);
      check_num(u_host.at[i], exp_edge(a, i, code));
    end
  endtask
  task automatic do_reset();
    @(negedge mclk) rst = 1'b1;
    // The link side needs its own clock edges to see reset
    repeat (4) u_host.tick();
    @(negedge mclk) rst = 1'b0;
    repeat (4) u_host.tick();
    check_word({13'h0000, load_ready, burst_busy, sync_mode}, 16'h0004);
  endtask
  initial begin
    int code, len;
    logic [15:0] low;
    logic [15:0] high;
    rst = 1'b1;
    load_valid = 1'b0;
    load_addr = '0;
    load_data = '0;
    errors = 0;
    n_compared = 0;
    do_reset();
    for (int i = 0; i < 1024; i++) begin
      @(negedge mclk);
      load_valid = 1'b1;
      load_addr = AW'(i);
      load_data = 16'($random(seed));
      mem[i] = load_data;
    end
    @(negedge mclk) load_valid = 1'b0;
    cfg_word(0, burst_pkg::BURST_CONFIG_LOW_RESET);
    cfg_word(1, burst_pkg::BURST_CONFIG_HIGH_RESET);
    burst(60, 0, 1);
    for (int k = 0; k < 12; k++) begin
      code = k % 6;
      len = k % 3;
      low = {1'b0, 1'b1, 3'(code), 9'h000, 2'(len)};
      u_host.frame(AW'(burst_pkg::CMD_CFG_WRITE_LOW), 1'b1, low, 1);
      // Upper bits random to prove the whole word is kept; wait msb stays 0
      high = {15'($random(seed)), 1'b0};
      u_host.frame(AW'(burst_pkg::CMD_CFG_WRITE_HIGH), 1'b1, high, 1);
      check_word({15'h0000, sync_mode}, 16'h0001);
      cfg_word(0, low);
      cfg_word(1, high);
      burst(k < 4 ? corner[k] : $random(seed) & 1023, code, len == 1 ? 16 : len == 2 ? 32 : 8);
    end
    // Cut a 32-word burst with wait code 5 after four words; deselect must silence it
    u_host.frame(AW'(200), 1'b0, 16'h0000, 9);
    check_num(u_host.got.size(), 4);
    check_word(u_host.got[0], mem[200]);
    do_reset();
    cfg_word(0, burst_pkg::BURST_CONFIG_LOW_RESET);
    test_done();
  end
  initial begin
    #200us;
    errors++;
    test_done();
  end
endmodule
